// *** rtl/srbank_top.sv ***
`timescale 1ns/1ps
module srbank_top (
  // Clock and main supply reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power-good pin, asynchronous
  input wire logic power_good_input,
  // Per-block sleep requests and sleep resets
  input wire logic [srbank_pkg::NUM_BLK-1:0] blk_sleep,
  output logic [srbank_pkg::NUM_BLK-1:0] blk_sleep_rst
);
  // Block index to enable: 0..15 controller bits, 16 RTC, 17 serial port zero
  localparam int CTRL_POS [16] = '{
    srbank_pkg::POS_CTRL_TMR1, srbank_pkg::POS_CTRL_TMR0,
    srbank_pkg::POS_CTRL_REGBANK, srbank_pkg::POS_CTRL_PULSE_MODULATOR_THREE,
    srbank_pkg::POS_CTRL_PULSE_MODULATOR_TWO, srbank_pkg::POS_CTRL_PULSE_MODULATOR_ONE,
    srbank_pkg::POS_CTRL_SPEED1, srbank_pkg::POS_CTRL_TWOWIRE0,
    srbank_pkg::POS_CTRL_WATCHDOG, srbank_pkg::POS_CTRL_PROC,
    srbank_pkg::POS_CTRL_TRACE, srbank_pkg::POS_CTRL_DMA,
    srbank_pkg::POS_CTRL_PWRMGR, srbank_pkg::POS_CTRL_PULSE_MODULATOR_ZERO,
    srbank_pkg::POS_CTRL_SPEED0, srbank_pkg::POS_CTRL_INTAGG};

  srbank_pkg::srbank_state_t st;
  srbank_pkg::srbank_state_t next_st;
  logic [srbank_pkg::NUM_BLK-1:0] blk_en;
  logic access;
  logic wr;

  assign access = psel && penable;
  assign wr = access && pwrite;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_ctrl
      assign blk_en[gi] = st.ctrl_en[CTRL_POS[gi]];
    end
  endgenerate
  assign blk_en[16] = st.host_en[srbank_pkg::POS_HOST_RTC];
  assign blk_en[17] = st.host_en[srbank_pkg::POS_HOST_SERIAL0];

  always_comb begin
    next_st = st;
    // Power-good path is not touched by rst so the bit stays live
    next_st.pg_sync = {st.pg_sync[1:0], power_good_input};
    if (st.pg_sync[2] == st.pg_sync[1]) begin
      next_st.pg_level = st.pg_sync[2];
    end
    next_st.blk_sleep_q = blk_sleep;
    // Reset follows enable and sleep together, dropping on wake
    next_st.blk_rst = blk_en & st.blk_sleep_q;
    next_st.pready = access && !st.pready;
    next_st.pslverr = 1'b0;
    next_st.prdata = 32'h0000_0000;
    if (access && !st.pready) begin
      unique case (paddr)
        srbank_pkg::OFF_PWR_RST_STS: begin
          next_st.prdata[srbank_pkg::POS_PWR_GOOD] = st.pg_level;
        end
        srbank_pkg::OFF_CHIP_EN: begin
          next_st.prdata = st.chip_en;
          if (wr) begin
            next_st.chip_en = pwdata & srbank_pkg::MASK_CHIP_EN;
          end
        end
        srbank_pkg::OFF_HOST_EN: begin
          next_st.prdata = st.host_en;
          if (wr) begin
            next_st.host_en = pwdata & srbank_pkg::MASK_HOST_EN;
          end
        end
        srbank_pkg::OFF_CTRL_EN: begin
          next_st.prdata = st.ctrl_en;
          if (wr) begin
            next_st.ctrl_en = pwdata & srbank_pkg::MASK_CTRL_EN;
          end
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
      if (wr) begin
        next_st.prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
    if (rst) begin
      st.chip_en <= srbank_pkg::RST_EN;
      st.host_en <= srbank_pkg::RST_EN;
      st.ctrl_en <= srbank_pkg::RST_EN;
      st.blk_rst <= '0;
      st.blk_sleep_q <= '0;
      st.prdata <= 32'h0000_0000;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign blk_sleep_rst = st.blk_rst;

  // Assertions
  property p_reset_follows;
    @(posedge clk) disable iff (rst)
      (blk_en[0] && st.blk_sleep_q[0]) |=> blk_sleep_rst[0];
  endproperty
  a_reset_follows: assert property (p_reset_follows) else $error("sleep reset missed");

  property p_no_reset_awake;
    @(posedge clk) disable iff (rst)
      (blk_sleep_rst & ~$past(blk_sleep, 2)) == '0;
  endproperty
  a_no_reset_awake: assert property (p_no_reset_awake) else $error("reset while awake");

  property p_en_cleared;
    @(posedge clk) $past(rst)
      |-> (st.ctrl_en == 32'h0 && st.host_en == 32'h0 && st.chip_en == 32'h0);
  endproperty
  a_en_cleared: assert property (p_en_cleared) else $error("enable not cleared");

  property p_pg_read;
    @(posedge clk) disable iff (rst)
      (access && !pready && !pwrite && paddr == srbank_pkg::OFF_PWR_RST_STS)
      |=> prdata[srbank_pkg::POS_PWR_GOOD] == $past(st.pg_level);
  endproperty
  a_pg_read: assert property (p_pg_read) else $error("power good status wrong");

  sequence s_pg_stable;
    power_good_input [*5];
  endsequence
  property p_pg_live;
    @(posedge clk) s_pg_stable |-> st.pg_level;
  endproperty
  a_pg_live: assert property (p_pg_live) else $error("power good not followed");

  property p_host_write;
    @(posedge clk) disable iff (rst)
      (wr && !pready && paddr == srbank_pkg::OFF_HOST_EN)
      |=> st.host_en[srbank_pkg::POS_HOST_RTC] == $past(pwdata[srbank_pkg::POS_HOST_RTC]);
  endproperty
  a_host_write: assert property (p_host_write) else $error("rtc enable not written");

  property p_ctrl_write;
    @(posedge clk) disable iff (rst)
      (wr && !pready && paddr == srbank_pkg::OFF_CTRL_EN)
      |=> st.ctrl_en[srbank_pkg::POS_CTRL_TMR1] == $past(pwdata[srbank_pkg::POS_CTRL_TMR1]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("timer enable not written");

  property p_serial_rst;
    @(posedge clk) disable iff (rst)
      (st.host_en[srbank_pkg::POS_HOST_SERIAL0] && st.blk_sleep_q[17]) |=> blk_sleep_rst[17];
  endproperty
  a_serial_rst: assert property (p_serial_rst) else $error("serial reset missed");

  property p_ready_one;
    @(posedge clk) disable iff (rst) pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready held");

  // Bus phase decodes shared by the checks below
  logic addr_hit;
  assign addr_hit = paddr inside {srbank_pkg::OFF_PWR_RST_STS, srbank_pkg::OFF_CHIP_EN,
    srbank_pkg::OFF_HOST_EN, srbank_pkg::OFF_CTRL_EN};

  sequence s_read(logic [7:0] a);
    access && !pready && !pwrite && paddr == a;
  endsequence
  sequence s_write(logic [7:0] a);
    wr && !pready && paddr == a;
  endsequence

  property p_ready_answer;
    @(posedge clk) disable iff (rst)
      (access && !pready) |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("pready missing");

  property p_ready_idle;
    @(posedge clk) disable iff (rst)
      !access |=> !pready;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("pready without access");

  property p_err_with_ready;
    @(posedge clk) disable iff (rst) pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr alone");

  property p_err_unmapped;
    @(posedge clk) disable iff (rst)
      (access && !pready && !addr_hit) |=> (pready && pslverr);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");

  property p_err_mapped;
    @(posedge clk) disable iff (rst)
      (access && !pready && addr_hit) |=> !pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");

  property p_read_chip;
    @(posedge clk) disable iff (rst)
      s_read(srbank_pkg::OFF_CHIP_EN) |=> prdata == $past(st.chip_en);
  endproperty
  a_read_chip: assert property (p_read_chip) else $error("chip enable read wrong");

  property p_read_host;
    @(posedge clk) disable iff (rst)
      s_read(srbank_pkg::OFF_HOST_EN) |=> prdata == $past(st.host_en);
  endproperty
  a_read_host: assert property (p_read_host) else $error("host read wrong");

  property p_read_ctrl;
    @(posedge clk) disable iff (rst)
      s_read(srbank_pkg::OFF_CTRL_EN) |=> prdata == $past(st.ctrl_en);
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("ctrl read wrong");

  property p_write_zero;
    @(posedge clk) disable iff (rst)
      (wr && !pready) |=> prdata == 32'h0;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("write returned data");

  property p_status_rest;
    @(posedge clk) disable iff (rst)
      s_read(srbank_pkg::OFF_PWR_RST_STS) |=> (prdata & ~(32'h1 << srbank_pkg::POS_PWR_GOOD)) == 32'h0;
  endproperty
  a_status_rest: assert property (p_status_rest) else $error("status spare bits set");

  property p_status_nowrite;
    @(posedge clk) disable iff (rst)
      s_write(srbank_pkg::OFF_PWR_RST_STS)
      |=> $stable(st.chip_en) && $stable(st.host_en)
        && $stable(st.ctrl_en);
  endproperty
  a_status_nowrite: assert property (p_status_nowrite) else $error("status write landed");

  property p_idle_hold;
    @(posedge clk) disable iff (rst)
      !(wr && !pready)
      |=> $stable(st.chip_en) && $stable(st.host_en)
        && $stable(st.ctrl_en);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("enable moved without write");

  sequence s_pg_low;
    (!power_good_input) [*5];
  endsequence
  property p_pg_low;
    @(posedge clk) s_pg_low |-> !st.pg_level;
  endproperty
  a_pg_low: assert property (p_pg_low) else $error("power good low not followed");

  property p_pg_glitch;
    @(posedge clk) (st.pg_sync[2] != st.pg_sync[1]) |=> st.pg_level == $past(st.pg_level);
  endproperty
  a_pg_glitch: assert property (p_pg_glitch) else $error("power good took a glitch");

  property p_rst_outputs;
    @(posedge clk) rst |=> (blk_sleep_rst == '0 && !pready && !pslverr);
  endproperty
  a_rst_outputs: assert property (p_rst_outputs) else $error("outputs live in reset");

  genvar bi;
  generate
    for (bi = 0; bi < 32; bi++) begin : g_field_chk
      property p_ctrl_bit;
        @(posedge clk) disable iff (rst)
          s_write(srbank_pkg::OFF_CTRL_EN)
          |=> st.ctrl_en[bi] == ($past(pwdata[bi]) & srbank_pkg::MASK_CTRL_EN[bi]);
      endproperty
      a_ctrl_bit: assert property (p_ctrl_bit)
        else $error("controller enable bit wrong");
      property p_host_bit;
        @(posedge clk) disable iff (rst)
          s_write(srbank_pkg::OFF_HOST_EN)
          |=> st.host_en[bi] == ($past(pwdata[bi]) & srbank_pkg::MASK_HOST_EN[bi]);
      endproperty
      a_host_bit: assert property (p_host_bit)
        else $error("host enable bit wrong");
      property p_chip_bit;
        @(posedge clk) disable iff (rst)
          s_write(srbank_pkg::OFF_CHIP_EN)
          |=> st.chip_en[bi] == ($past(pwdata[bi]) & srbank_pkg::MASK_CHIP_EN[bi]);
      endproperty
      a_chip_bit: assert property (p_chip_bit)
        else $error("chip enable bit wrong");
    end
  endgenerate

  genvar ki;
  generate
    for (ki = 0; ki < srbank_pkg::NUM_BLK; ki++) begin : g_blk_chk
      // Sleep is seen one edge late, so entry and exit each take two edges
      sequence s_enter;
        (blk_en[ki] && blk_sleep[ki]) ##1 (blk_en[ki] && st.blk_sleep_q[ki]);
      endsequence
      sequence s_exit;
        blk_sleep[ki] ##1 !blk_sleep[ki];
      endsequence
      property p_blk_map;
        @(posedge clk) disable iff (rst) blk_sleep_rst[ki] |-> $past(blk_sleep[ki], 2);
      endproperty
      a_blk_map: assert property (p_blk_map) else $error("reset while awake");
      property p_blk_off;
        @(posedge clk) disable iff (rst) !blk_en[ki] |=> !blk_sleep_rst[ki];
      endproperty
      a_blk_off: assert property (p_blk_off) else $error("reset while disabled");
      property p_blk_had_en;
        @(posedge clk) disable iff (rst) blk_sleep_rst[ki] |-> $past(blk_en[ki]);
      endproperty
      a_blk_had_en: assert property (p_blk_had_en) else $error("reset without enable");
      property p_blk_enter;
        @(posedge clk) disable iff (rst) s_enter |=> blk_sleep_rst[ki];
      endproperty
      a_blk_enter: assert property (p_blk_enter) else $error("sleep reset late");
      property p_blk_exit;
        @(posedge clk) disable iff (rst) s_exit |=> ##1 !blk_sleep_rst[ki];
      endproperty
      a_blk_exit: assert property (p_blk_exit) else $error("reset held on wake");
    end
  endgenerate
endmodule : srbank_top

// *** shared/srbank_pkg.sv ***
package srbank_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_PWR_RST_STS = 8'h34;
  localparam logic [7:0] OFF_CHIP_EN = 8'h38;
  localparam logic [7:0] OFF_HOST_EN = 8'h3c;
  localparam logic [7:0] OFF_CTRL_EN = 8'h40;
  // Field positions
  localparam int POS_PWR_GOOD = 2;
  localparam int POS_HOST_RTC = 18;
  localparam int POS_HOST_SERIAL0 = 1;
  localparam int POS_CTRL_TMR1 = 31;
  localparam int POS_CTRL_TMR0 = 30;
  localparam int POS_CTRL_REGBANK = 29;
  localparam int POS_CTRL_PULSE_MODULATOR_THREE = 22;
  localparam int POS_CTRL_PULSE_MODULATOR_TWO = 21;
  localparam int POS_CTRL_PULSE_MODULATOR_ONE = 20;
  localparam int POS_CTRL_SPEED1 = 11;
  localparam int POS_CTRL_TWOWIRE0 = 10;
  localparam int POS_CTRL_WATCHDOG = 9;
  localparam int POS_CTRL_PROC = 8;
  localparam int POS_CTRL_TRACE = 7;
  localparam int POS_CTRL_DMA = 6;
  localparam int POS_CTRL_PWRMGR = 5;
  localparam int POS_CTRL_PULSE_MODULATOR_ZERO = 4;
  localparam int POS_CTRL_SPEED0 = 2;
  localparam int POS_CTRL_SPARE1 = 1;
  localparam int POS_CTRL_INTAGG = 0;
  // Writable masks
  localparam logic [31:0] MASK_CHIP_EN = 32'h0000_0001;
  localparam logic [31:0] MASK_HOST_EN = 32'h0004_0003;
  localparam logic [31:0] MASK_CTRL_EN = 32'he070_0ff7;
  // Reset values
  localparam logic [31:0] RST_EN = 32'h0000_0000;
  // Number of sleep-reset outputs
  localparam int NUM_BLK = 18;
  typedef struct packed {
    logic [NUM_BLK-1:0] blk_rst;
    logic [NUM_BLK-1:0] blk_sleep_q;
    logic [2:0] pg_sync;
    logic pg_level;
    logic [31:0] chip_en;
    logic [31:0] host_en;
    logic [31:0] ctrl_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } srbank_state_t;
endpackage : srbank_pkg

// *** tb/srbank_blk_model.sv ***
`timescale 1ns/1ps
module srbank_blk_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sleep command in, sleep level out
  input wire logic [srbank_pkg::NUM_BLK-1:0] sleep_cmd,
  output logic [srbank_pkg::NUM_BLK-1:0] blk_sleep
);
  // Blocks only change sleep state on a clock edge; the bench never
  // writes a block while it sleeps under reset
  always_ff @(posedge clk) begin
    if (rst) begin
      blk_sleep <= '0;
    end else begin
      blk_sleep <= sleep_cmd;
    end
  end
endmodule : srbank_blk_model

// *** tb/tb_srbank_top.sv ***
`timescale 1ns/1ps
module tb_srbank_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic pg = 1'b0;
  logic [17:0] cmd = '0;
  logic [17:0] slp, srst;
  int n_errors = 0;
  int num_checks = 0;
  int pos[18] = '{31, 30, 29, 22, 21, 20, 11, 10, 9, 8, 7, 6, 5, 4, 2, 0, 18, 1};
  always #5 clk = ~clk;
  srbank_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_good_input(pg),
    .blk_sleep(slp), .blk_sleep_rst(srst));
  srbank_blk_model blk_u (.clk(clk), .rst(rst), .sleep_cmd(cmd), .blk_sleep(slp));
  task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  // Waits a whole edge first so a release and a new setup never share a time step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready is read at the rising edge, before that edge's own updates land
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) check(1'b0, 1'b1, "no pready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #300000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, srbank_pkg::OFF_CTRL_EN, 0);
    check(rd, srbank_pkg::RST_EN, "ctrl reset");
    apb(1'b0, srbank_pkg::OFF_HOST_EN, 0);
    check(rd, srbank_pkg::RST_EN, "host reset");
    check(er, 1'b0, "mapped ok");
    apb(1'b0, srbank_pkg::OFF_CHIP_EN, 0);
    check(rd, srbank_pkg::RST_EN, "chip reset");
    apb(1'b1, srbank_pkg::OFF_CHIP_EN, 32'hffff_ffff);
    apb(1'b0, srbank_pkg::OFF_CHIP_EN, 0);
    check(rd, srbank_pkg::MASK_CHIP_EN, "chip mask");
    apb(1'b1, srbank_pkg::OFF_CTRL_EN, 32'hffff_ffff);
    apb(1'b0, srbank_pkg::OFF_CTRL_EN, 0);
    check(rd, srbank_pkg::MASK_CTRL_EN, "ctrl mask");
    apb(1'b1, srbank_pkg::OFF_HOST_EN, 32'hffff_ffff);
    apb(1'b0, srbank_pkg::OFF_HOST_EN, 0);
    check(rd, srbank_pkg::MASK_HOST_EN, "host mask");
    apb(1'b0, 8'h50, 0);
    check(er, 1'b1, "unmapped");
    apb(1'b0, srbank_pkg::OFF_PWR_RST_STS, 0);
    check(rd, 32'h0, "pg low");
    pg <= 1'b1;
    apb(1'b1, srbank_pkg::OFF_PWR_RST_STS, 32'h0);
    repeat (8) @(posedge clk);
    apb(1'b0, srbank_pkg::OFF_PWR_RST_STS, 0);
    check(rd, 32'h4, "pg high");
    $display("test registers done");
    for (int i = 0; i < 18; i++) begin
      apb(1'b1, srbank_pkg::OFF_CTRL_EN, (i < 16) ? 32'h1 << pos[i] : 32'h0);
      apb(1'b1, srbank_pkg::OFF_HOST_EN, (i >= 16) ? 32'h1 << pos[i] : 32'h0);
      cmd <= '1;
      repeat (4) @(posedge clk);
      check(32'(srst), 32'h1 << i, "map");
      cmd <= '0;
      repeat (4) @(posedge clk);
      check(32'(srst), 32'h0, "wake");
    end
    $display("test sleep map done");
    apb(1'b1, srbank_pkg::OFF_CTRL_EN, 32'hffff_ffff);
    cmd <= '1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(srst), 32'h0, "in reset");
    rst <= 1'b0;
    apb(1'b0, srbank_pkg::OFF_CTRL_EN, 0);
    check(rd, 32'h0, "ctrl cleared");
    check(32'(srst), 32'h0, "no reset");
    apb(1'b0, srbank_pkg::OFF_PWR_RST_STS, 0);
    check(rd, 32'h4, "pg kept");
    pg <= 1'b0;
    repeat (8) @(posedge clk);
    apb(1'b0, srbank_pkg::OFF_PWR_RST_STS, 0);
    check(rd, 32'h0, "pg fell");
    $display("test mid reset done");
    report_and_stop();
  end
endmodule : tb_srbank_top
